// file: dv/test_windowed_watchdog_timer.sv
/*
  Self-checking bench for the windowed watchdog timer.
  Assumes one slow tick every 16 system clocks and overflow select 0.
*/
`timescale 1ns/100ps
module test_windowed_watchdog_timer;
  logic       clock = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_bit_op = 1'b0, reg_read = 1'b0;
  logic       halt_mode = 1'b0, stop_mode = 1'b0, low_speed_osc_clock = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, option_byte = 8'h00, reg_rdata, d;
  logic       internal_reset, irq;
  int         n_fail = 0, samples_checked = 0, k;
  always #5 clock = ~clock;
  always #80 low_speed_osc_clock = ~low_speed_osc_clock;
  windowed_watchdog_timer i_windowed_watchdog_timer (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_bit_op(reg_bit_op), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .option_byte(option_byte), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .low_speed_osc_clock(low_speed_osc_clock), .internal_reset(internal_reset), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic b = 1'b0);
    reg_addr <= a;
    reg_wdata <= v;
    reg_bit_op <= b;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_bit_op <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clock);
    #1;
  endtask
  task automatic wait_cnt(input logic [7:0] t);
    d = 8'h00;
    k = 0;
    while (d < t && k < 800) begin
      rd(wdt_pkg::ADDR_COUNT_LO);
      k++;
    end
    if (k >= 800) n_fail++;
  endtask
  task automatic do_reset(input logic [7:0] opt);
    sys_rst <= 1'b1;
    option_byte <= opt;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end
  initial begin
    do_reset(8'hb1);
    rd(wdt_pkg::ADDR_SERVICE);
    chk(d, wdt_pkg::READ_FRESH);
    wait_cnt(8'h0a);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    chk(8'(internal_reset), 8'h00);
    rd(wdt_pkg::ADDR_SERVICE);
    chk(d, wdt_pkg::READ_SERVICED);
    rd(wdt_pkg::ADDR_COUNT_LO);
    chk(d & 8'hfe, 8'h00);
    rd(wdt_pkg::ADDR_COUNT_HI);
    chk(d, 8'h00);
    rd(wdt_pkg::ADDR_STATUS);
    chk(d, 8'h02);
    wr(wdt_pkg::ADDR_ENABLE, 8'h03);
    chk(8'(irq), 8'h01);
    wr(wdt_pkg::ADDR_CLEAR, 8'h02);
    chk(8'(irq), 8'h00);
    rd(4'hf);
    chk(d, 8'h00);
    wait_cnt(8'h60);
    rd(wdt_pkg::ADDR_STATUS);
    chk(d, 8'h01);
    chk(8'(irq), 8'h01);
    wr(wdt_pkg::ADDR_CLEAR, 8'h01);
    wait_cnt(8'h7f);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    repeat (40) @(posedge clock);
    #1;
    chk(8'(internal_reset), 8'h00);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    chk(8'(internal_reset), 8'h01);
    do_reset(8'hb1);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    k = 0;
    while (!internal_reset && k < 3000) begin
      @(posedge clock);
      k++;
    end
    chk(8'(k >= 2000 && k <= 2090), 8'h01);
    do_reset(8'hb1);
    wr(wdt_pkg::ADDR_SERVICE, 8'h55);
    chk(8'(internal_reset), 8'h01);
    do_reset(8'hb1);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY, 1'b1);
    chk(8'(internal_reset), 8'h01);
    do_reset(8'h91);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    wait_cnt(8'h40);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    chk(8'(internal_reset), 8'h01);
    do_reset(8'hd1);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    wait_cnt(8'h28);
    wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
    chk(8'(internal_reset), 8'h00);
    for (int m = 0; m < 2; m++) begin
      do_reset(8'hb0);
      wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
      halt_mode <= (m == 0);
      stop_mode <= (m == 1);
      repeat (60) @(posedge clock);
      rd(wdt_pkg::ADDR_COUNT_LO);
      chk(d, 8'h00);
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
      repeat (50) @(posedge clock);
      rd(wdt_pkg::ADDR_COUNT_LO);
      chk(8'(d > 0 && d < 5), 8'h01);
      wr(wdt_pkg::ADDR_SERVICE, wdt_pkg::SERVICE_KEY);
      chk(8'(internal_reset), 8'h00);
    end
    wr(wdt_pkg::ADDR_ENABLE, 8'h00);
    summarize();
  end
endmodule

// file: dv/windowed_watchdog_timer_asserts.sv
/*
  Port-level checker for the windowed watchdog timer.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module windowed_watchdog_timer_asserts #(
  parameter int CNT_W = 15
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_write,
  input wire logic                       reg_bit_op,
  input wire logic                       reg_read,
  input wire logic [wdt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [wdt_pkg::DATA_W-1:0] option_byte,
  input wire logic                       halt_mode,
  input wire logic                       stop_mode,
  input wire logic                       low_speed_osc_clock,
  input wire logic                       internal_reset,
  input wire logic                       irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_svc_wr;
    reg_write && reg_addr == wdt_pkg::ADDR_SERVICE && !internal_reset;
  endsequence
  sequence s_hold2;
    internal_reset [*2];
  endsequence
  property p_bad_key;
    s_svc_wr ##0 (reg_wdata != wdt_pkg::SERVICE_KEY) |=> s_hold2;
  endproperty
  property p_bit_op;
    s_svc_wr ##0 reg_bit_op |=> s_hold2;
  endproperty
  property p_read_pat;
    reg_read && reg_addr == wdt_pkg::ADDR_SERVICE |=>
      (reg_rdata == wdt_pkg::READ_FRESH || reg_rdata == wdt_pkg::READ_SERVICED);
  endproperty
  property p_rdata_idle;
    !reg_read |=> reg_rdata == wdt_pkg::READ_ZERO;
  endproperty
  property p_sticky;
    internal_reset |=> internal_reset;
  endproperty
  property p_rst_out;
    $fell(sys_rst) |-> !internal_reset && !irq && reg_rdata == 8'h00;
  endproperty
  property p_irq_mask;
    reg_write && reg_addr == wdt_pkg::ADDR_ENABLE && reg_wdata == 8'h00 |=> !irq;
  endproperty
  property p_cnt_hi;
    reg_read && reg_addr == wdt_pkg::ADDR_COUNT_HI |=> (reg_rdata >> (CNT_W - 8)) == 8'h00;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_bad_key: assert property (p_bad_key) else $error("non-key service write did not trip");
  a_bit_op: assert property (p_bit_op) else $error("bit write to service did not trip");
  a_read_pat: assert property (p_read_pat) else $error("service read pattern wrong");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_sticky: assert property (p_sticky) else $error("internal reset dropped early");
  a_rst_out: assert property (p_rst_out) else $error("outputs not zero after reset");
  a_irq_mask: assert property (p_irq_mask) else $error("irq high with all enables off");
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high bits not zero");
endmodule
bind windowed_watchdog_timer windowed_watchdog_timer_asserts #(.CNT_W(CNT_W)) i_windowed_watchdog_timer_asserts (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_bit_op(reg_bit_op), .reg_read(reg_read), .reg_rdata(reg_rdata), .option_byte(option_byte),
  .halt_mode(halt_mode), .stop_mode(stop_mode), .low_speed_osc_clock(low_speed_osc_clock),
  .internal_reset(internal_reset), .irq(irq));

// file: rtl/level_sync3.sv
/*
  Three-stage synchroniser for a level from another clock domain.
  Assumes the level changes slower than a few clock periods.
*/
`timescale 1ns/100ps
module level_sync3 (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Asynchronous input
  input  wire logic async_in,
  // Filtered level
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  ////////////////////////////////////////////////////////////////////////////
  // A change counts once the second and third stages agree
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule

// file: rtl/wdt_pkg.sv
/*
  Constants, register map and types of the windowed watchdog timer.
  Assumes an 8-bit register port with a 4-bit address.
*/
package wdt_pkg;

  // Register port shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_SERVICE  = 4'h0;
  localparam logic [3:0] ADDR_OPTION   = 4'h1;
  localparam logic [3:0] ADDR_STATUS   = 4'h2;
  localparam logic [3:0] ADDR_CLEAR    = 4'h3;
  localparam logic [3:0] ADDR_ENABLE   = 4'h4;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h5;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h6;

  // Service register values
  localparam logic [7:0] SERVICE_KEY   = 8'hac;
  localparam logic [7:0] READ_FRESH    = 8'h9a;
  localparam logic [7:0] READ_SERVICED = 8'h1a;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Overflow period is 2^(OVF_BASE + overflow select) low-speed ticks
  localparam int OVF_BASE = 7;
  localparam int OVF_SEL_MAX = 7;

  // Window size select codes
  localparam logic [1:0] WIN_25  = 2'h0;
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h2;
  localparam logic [1:0] WIN_100 = 2'h3;

  // Option byte layout, bit 0 is the standby-run select
  typedef struct packed {
    logic       interval_en;
    logic       window_size_select_hi;
    logic       window_size_select_lo;
    logic       wdt_on;
    logic [2:0] ovf_sel;
    logic       standby_run_select;
  } option_t;

  localparam option_t OPTION_RESET = option_t'(8'h00);

  // Status, clear and enable share this layout
  typedef struct packed {
    logic [5:0] unused;
    logic       serviced;
    logic       interval;
  } events_t;

  localparam events_t EVENTS_NONE = events_t'(8'h00);

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN   = 2'b10,
    ST_TRIP  = 2'b11
  } wdt_state_t;

endpackage

// file: rtl/windowed_watchdog_timer.sv
/*
  Windowed watchdog timer counting on the low-speed oscillator clock.
  Assumes the CPU drives the register port on the system clock, that the
  internal reset output is fed back to sys_rst, and that the option byte
  is stable when sys_rst is released.
*/
//
// Summary of operation
// - Writing anything but the key to the service register trips reset.
// - A single-bit manipulation of the service register trips reset.
// - Service register reads give one of two fixed patterns, never the key.
// - First write after reset clears and restarts regardless of the window.
// - After a key clear, overflow may shift by up to one slow tick.
// - A key write is accepted up to the last count before overflow.
// - Counter overflow trips the internal reset.
// - Option byte bit 0 selects standby behaviour.
// - Standby-run select 0: counter held at zero in sleep, clears and resumes after.
// - Standby-run select 0 forces a full-period open window.
// - Counting never pauses for flash programming or emulation.
`timescale 1ns/100ps
module windowed_watchdog_timer #(
  parameter int CNT_W = 15
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  // Register port
  input  wire logic [wdt_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [wdt_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_bit_op,
  input  wire logic                           reg_read,
  output logic      [wdt_pkg::DATA_W-1:0]     reg_rdata,
  // Device context
  input  wire logic [wdt_pkg::DATA_W-1:0]     option_byte,
  input  wire logic                           halt_mode,
  input  wire logic                           stop_mode,
  input  wire logic                           low_speed_osc_clock,
  // Outputs
  output logic                                internal_reset,
  output logic                                irq
);

  if (CNT_W < wdt_pkg::OVF_BASE + wdt_pkg::OVF_SEL_MAX + 1) begin : g_check
    $error("CNT_W too small for the longest overflow period");
  end
  if (CNT_W > 2 * wdt_pkg::DATA_W) begin : g_check_read
    $error("CNT_W too wide for the two count read bytes");
  end
  if (wdt_pkg::OVF_BASE < 2) begin : g_check_quarter
    $error("Overflow period too short for quarter window points");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-speed clock tick

  logic slow_level;
  logic slow_prev;
  logic slow_tick;
  logic next_slow_prev;

  level_sync3 u_slow_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (low_speed_osc_clock),
    .level    (slow_level)
  );

  // Synchroniser latency lets a clear land up to one slow tick off
  always_comb begin
    next_slow_prev = slow_level;
    slow_tick      = slow_level & ~slow_prev;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slow_prev <= 1'b0;
    end else begin
      slow_prev <= next_slow_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option byte capture

  wdt_pkg::option_t option;
  wdt_pkg::option_t next_option;
  wdt_pkg::option_t option_in;
  logic             option_loaded;
  logic             next_option_loaded;
  logic             wdt_enabled;

  // The watchdog only starts when the option byte turns it on
  assign option_in   = wdt_pkg::option_t'(option_byte);
  assign wdt_enabled = option_in.wdt_on;

  always_comb begin
    next_option        = option;
    next_option_loaded = 1'b1;
    if (!option_loaded) begin
      next_option = option_in;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      option        <= wdt_pkg::OPTION_RESET;
      option_loaded <= 1'b0;
    end else begin
      option        <= next_option;
      option_loaded <= next_option_loaded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period, window and interval points

  logic [CNT_W:0]   period;
  logic [CNT_W-1:0] last_count;
  logic [CNT_W-1:0] open_from;
  logic [CNT_W-1:0] interval_point;
  logic [1:0]       window_sel;
  logic             window_open;
  logic             sleeping;
  logic             sleep_prev;
  logic             next_sleep_prev;
  logic             counting;

  always_comb begin
    period         = (CNT_W+1)'(1) << (wdt_pkg::OVF_BASE + int'(option.ovf_sel));
    last_count     = CNT_W'(period - (CNT_W+1)'(1));
    interval_point = CNT_W'(period - (period >> 2));
  end

  // Window start, forced open all period without standby running
  always_comb begin
    window_sel     = {option.window_size_select_hi, option.window_size_select_lo};
    if (!option.standby_run_select) begin
      window_sel = wdt_pkg::WIN_100;
    end
    unique case (window_sel)
      wdt_pkg::WIN_25:  open_from = CNT_W'(period - (period >> 2));
      wdt_pkg::WIN_50:  open_from = CNT_W'(period >> 1);
      wdt_pkg::WIN_75:  open_from = CNT_W'(period >> 2);
      wdt_pkg::WIN_100: open_from = '0;
    endcase
  end

  assign sleeping = halt_mode | stop_mode;
  // Flash self-programming has no input here: only sleep pauses the count
  assign counting = !(sleeping && !option.standby_run_select);

  always_comb begin
    next_sleep_prev = sleeping;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sleep_prev <= 1'b0;
    end else begin
      sleep_prev <= next_sleep_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service register decode

  logic svc_write;
  logic svc_illegal;
  logic svc_key;

  assign svc_write   = reg_write && (reg_addr == wdt_pkg::ADDR_SERVICE);
  assign svc_illegal = svc_write && (reg_bit_op || (reg_wdata != wdt_pkg::SERVICE_KEY));
  assign svc_key     = svc_write && !svc_illegal;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt register writes

  logic clear_write;
  logic enable_write;

  assign clear_write  = reg_write && (reg_addr == wdt_pkg::ADDR_CLEAR);
  assign enable_write = reg_write && (reg_addr == wdt_pkg::ADDR_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog state and counter

  wdt_pkg::wdt_state_t state;
  wdt_pkg::wdt_state_t next_state;
  logic [CNT_W-1:0]    count;
  logic [CNT_W-1:0]    next_count;
  logic                first_done;
  logic                next_first_done;
  logic                next_internal_reset;
  logic                ev_interval;
  logic                ev_serviced;

  assign window_open = (count >= open_from);

  always_comb begin
    next_state      = state;
    next_count      = count;
    next_first_done = first_done;
    ev_interval     = 1'b0;
    ev_serviced     = 1'b0;
    unique case (state)
      wdt_pkg::ST_OFF: begin
        if (svc_illegal) begin
          next_state = wdt_pkg::ST_TRIP;
        end else if (!option_loaded && wdt_enabled) begin
          next_state = wdt_pkg::ST_FIRST;
        end
      end
      wdt_pkg::ST_FIRST, wdt_pkg::ST_RUN: begin
        if (svc_illegal) begin
          next_state = wdt_pkg::ST_TRIP;
        end else if (svc_key && state == wdt_pkg::ST_FIRST) begin
          // First key after reset is taken at any count
          next_count      = '0;
          next_first_done = 1'b1;
          next_state      = wdt_pkg::ST_RUN;
          ev_serviced     = 1'b1;
        end else if (svc_key && !window_open) begin
          next_state = wdt_pkg::ST_TRIP;
        end else if (svc_key) begin
          next_count      = '0;
          next_first_done = 1'b1;
          ev_serviced     = 1'b1;
        end else if (!counting) begin
          next_count = '0;
        end else if (sleep_prev && !option.standby_run_select) begin
          next_count = '0;
        end else if (slow_tick) begin
          if (count == last_count) begin
            next_state = wdt_pkg::ST_TRIP;
          end else begin
            next_count  = count + CNT_W'(1);
            ev_interval = option.interval_en && (next_count == interval_point);
          end
        end
      end
      wdt_pkg::ST_TRIP: begin
        // Tripped: held until sys_rst
        next_state = wdt_pkg::ST_TRIP;
      end
    endcase
    next_internal_reset = (next_state == wdt_pkg::ST_TRIP);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state          <= wdt_pkg::ST_OFF;
      count          <= '0;
      first_done     <= 1'b0;
      internal_reset <= 1'b0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      first_done     <= next_first_done;
      internal_reset <= next_internal_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and output

  wdt_pkg::events_t status;
  wdt_pkg::events_t next_status;
  wdt_pkg::events_t enable;
  wdt_pkg::events_t next_enable;
  wdt_pkg::events_t clear_mask;
  wdt_pkg::events_t set_mask;
  logic             next_irq;

  always_comb begin
    next_enable = enable;
    if (enable_write) begin
      next_enable        = wdt_pkg::events_t'(reg_wdata);
      next_enable.unused = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable <= wdt_pkg::EVENTS_NONE;
    end else begin
      enable <= next_enable;
    end
  end

  always_comb begin
    clear_mask = wdt_pkg::EVENTS_NONE;
    set_mask   = wdt_pkg::EVENTS_NONE;
    if (clear_write) begin
      clear_mask = wdt_pkg::events_t'(reg_wdata);
    end
    set_mask.interval = ev_interval;
    set_mask.serviced = ev_serviced;
    // A set in the clearing cycle wins
    next_status        = (status & ~clear_mask) | set_mask;
    next_status.unused = '0;
    next_irq           = |(next_status & next_enable);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= wdt_pkg::EVENTS_NONE;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe

  logic [wdt_pkg::DATA_W-1:0] next_rdata;
  logic [2*wdt_pkg::DATA_W-1:0] count_wide;

  assign count_wide = (2*wdt_pkg::DATA_W)'(count);

  always_comb begin
    next_rdata = wdt_pkg::READ_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        wdt_pkg::ADDR_SERVICE:
          next_rdata = first_done ? wdt_pkg::READ_SERVICED : wdt_pkg::READ_FRESH;
        wdt_pkg::ADDR_OPTION:   next_rdata = option;
        wdt_pkg::ADDR_STATUS:   next_rdata = status;
        wdt_pkg::ADDR_CLEAR:    next_rdata = wdt_pkg::READ_ZERO;
        wdt_pkg::ADDR_ENABLE:   next_rdata = enable;
        wdt_pkg::ADDR_COUNT_LO: next_rdata = count_wide[wdt_pkg::DATA_W-1:0];
        wdt_pkg::ADDR_COUNT_HI: next_rdata = count_wide[2*wdt_pkg::DATA_W-1:wdt_pkg::DATA_W];
        default:                next_rdata = wdt_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= wdt_pkg::READ_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
